// >>> shared/lest_pkg.sv
package lest_pkg;
    localparam int unsigned CLK_HZ          = 125000000;
    localparam int unsigned TIMEOUT_MIN_DEF = 10;
    localparam int unsigned TIMEOUT_MIN_MIN = 1;
    localparam int unsigned TIMEOUT_MIN_MAX = 1500;
    localparam int unsigned SEC_PER_MIN     = 60;
    localparam longint unsigned MIN_CYCLES_DEF = 64'(CLK_HZ) * 64'(SEC_PER_MIN);
    localparam int unsigned POLL_SCANS      = 20;
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_TIMEOUT    = 12'h004;
    localparam logic [11:0] ADDR_STATUS     = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STAT   = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_EN     = 12'h010;
    localparam logic [11:0] ADDR_IRQ_CLR    = 12'h014;
    localparam logic [11:0] ADDR_STORE      = 12'h018;
    localparam logic [11:0] ADDR_HOURS      = 12'h01C;
    localparam logic [11:0] ADDR_INTERVALS  = 12'h020;
    localparam logic [11:0] ADDR_GOOD       = 12'h024;
    localparam logic [11:0] ADDR_MAXIV      = 12'h028;
    localparam logic [11:0] ADDR_MINIV      = 12'h02C;
    localparam logic [11:0] ADDR_QUALITY    = 12'h030;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_MODE_W     = 3;
    localparam int          STAT_LASER      = 0;
    localparam int          STAT_TIMEOUT    = 1;
    localparam int          STAT_FAULT      = 2;
    localparam int          IRQ_TIMEOUT     = 0;
    localparam int          IRQ_FAULT       = 1;
    localparam int          IRQ_W           = 2;
    localparam logic [31:0] MINIV_RESET     = 32'hFFFFFFFF;
    typedef enum logic [2:0] {
        LEST_MODE_SENSOR,
        LEST_MODE_SERIAL,
        LEST_MODE_POLLING,
        LEST_MODE_FREE_RUN,
        LEST_MODE_PERCENT_EVAL,
        LEST_MODE_ADJUSTING,
        LEST_MODE_CODE_POSITION_LIMIT_DISPLAY,
        LEST_MODE_AUTOMATIC_TUNING_MODE
    } lest_mode_t;
endpackage

// >>> hdl/lest_param_store.sv
`timescale 1ns/10ps
`default_nettype none
// permanent store stand-in: contents survive the block's own reset
module lest_param_store (
    input  wire logic        aclk,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    output logic [31:0]      rd_data
);
    typedef struct packed {
        logic [31:0] mem;
        logic [31:0] rd;
    } lest_store_state_t;
    lest_store_state_t s_reg;
    lest_store_state_t s_next;
    // no reset on purpose: this is the nonvolatile copy
    always_comb begin
        s_next = s_reg;
        if (wr_en) begin
            s_next.mem = wr_data;
        end
        s_next.rd = s_next.mem;
    end
    always_ff @(posedge aclk) begin
        s_reg <= s_next;
    end
    assign rd_data = s_reg.rd;
endmodule
`default_nettype wire

// >>> hdl/lest_laser_timer.sv
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1: laser follows reading pulse while reading
// R2: force off after continuous pulse timeout
// R3: emit timeout notification to terminal
// R4: stay off until next new pulse
// R5: timeout 1 min to 25 h, or off
// R6: special modes hold laser constantly on
// R7: reflector polling: laser every 20th scan
// R8: malfunction monitor overrides, laser off
// R9: power-up loads last permanently stored set
// R10: daily statistics cleared at every restart; the code sets min_iv to all ones instead
// R11: timeout count restarts at each new pulse
module lest_laser_timer #(
    parameter longint unsigned MIN_CYCLES = lest_pkg::MIN_CYCLES_DEF
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        sensor_pulse,
    input  wire logic        serial_pulse,
    input  wire logic        scan_start,
    input  wire logic        malfunction,
    input  wire logic        good_read,
    input  wire logic [7:0]  ident_quality,
    output logic             laser_enable,
    output logic             timeout_msg,
    output logic             irq,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int IRQ_W_L = lest_pkg::IRQ_W;
    typedef struct packed {
        logic        boot;
        logic [2:0]  mode;
        logic [10:0] tmo_min;
        logic        aw_got;
        logic [11:0] awaddr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        pulse_d;
        logic        tripped;
        logic [32:0] cyc_cnt; // a minute at full rate needs 33 bits
        logic [10:0] min_cnt;
        logic [4:0]  scan_cnt;
        logic        laser;
        logic        msg;
        logic [IRQ_W_L-1:0] irq_stat;
        logic [IRQ_W_L-1:0] irq_en;
        logic [31:0] sec_cyc;
        logic [31:0] hours_sec;
        logic [31:0] intervals;
        logic [31:0] good;
        logic [31:0] iv_len;
        logic [31:0] max_iv;
        logic [31:0] min_iv;
        logic [31:0] qual_sum;
    } lest_state_t;
    localparam logic [32:0] MIN_CYC = 33'(MIN_CYCLES);
    localparam logic [31:0] SEC_CYC = 32'(lest_pkg::CLK_HZ);
    localparam logic [10:0] TMO_DEF = 11'(lest_pkg::TIMEOUT_MIN_DEF);
    localparam logic [10:0] TMO_LO  = 11'(lest_pkg::TIMEOUT_MIN_MIN);
    localparam logic [10:0] TMO_HI  = 11'(lest_pkg::TIMEOUT_MIN_MAX);
    localparam logic [4:0]  POLL_LAST = 5'(lest_pkg::POLL_SCANS - 1);

    lest_state_t s_reg;
    lest_state_t s_next;
    logic        store_wr;
    logic [31:0] store_rd;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_const_on(input logic [2:0] m);
        return (m == lest_pkg::LEST_MODE_FREE_RUN) || (m == lest_pkg::LEST_MODE_PERCENT_EVAL) ||
               (m == lest_pkg::LEST_MODE_ADJUSTING) ||
               (m == lest_pkg::LEST_MODE_CODE_POSITION_LIMIT_DISPLAY) ||
               (m == lest_pkg::LEST_MODE_AUTOMATIC_TUNING_MODE);
    endfunction

    // only the pulse-driven modes carry the safety timeout
    function automatic logic is_timed(input logic [2:0] m);
        return (m == lest_pkg::LEST_MODE_SENSOR) || (m == lest_pkg::LEST_MODE_SERIAL);
    endfunction

    lest_param_store u_store (
        .aclk    (aclk),
        .wr_en   (store_wr),
        .wr_data (s_reg.wdata),
        .rd_data (store_rd)
    );

    logic        pulse;
    logic        pulse_rise;
    logic        do_wr;
    logic [31:0] wv;
    logic [31:0] stat_word;
    logic [IRQ_W_L-1:0] ev;

    always_comb begin
        s_next     = s_reg;
        pulse      = (s_reg.mode == lest_pkg::LEST_MODE_SERIAL) ? serial_pulse : sensor_pulse;
        pulse_rise = pulse && !s_reg.pulse_d;
        do_wr      = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
        wv         = 32'h00000000;
        store_wr   = 1'b0;
        ev         = '0;
        s_next.msg = 1'b0;
        s_next.pulse_d = pulse;

        // power-up: take the permanently stored set once
        if (s_reg.boot) begin // [R9]
            s_next.boot    = 1'b0;
            s_next.mode    = store_rd[2:0];
            s_next.tmo_min = store_rd[18:8];
        end

        // safety timer, minutes counted only while pulse held
        // other modes never trip, so no trip fights a forced-on laser
        if (pulse_rise) begin // [R11]
            s_next.cyc_cnt = 33'h0;
            s_next.min_cnt = 11'h000;
            s_next.tripped = 1'b0; // [R4]
        end else if (pulse && !s_reg.tripped && s_reg.tmo_min != 11'h000 && is_timed(s_reg.mode)) begin // [R5]
            if (s_reg.cyc_cnt == MIN_CYC - 33'h1) begin
                s_next.cyc_cnt = 33'h0;
                s_next.min_cnt = s_reg.min_cnt + 11'h001;
                if (s_reg.min_cnt + 11'h001 >= s_reg.tmo_min) begin // [R2]
                    s_next.tripped = 1'b1;
                    s_next.msg     = 1'b1; // [R3]
                    ev[lest_pkg::IRQ_TIMEOUT] = 1'b1;
                end
            end else begin
                s_next.cyc_cnt = s_reg.cyc_cnt + 33'h1;
            end
        end

        if (scan_start) begin // [R7]
            s_next.scan_cnt = (s_reg.scan_cnt == POLL_LAST) ? 5'h00 : s_reg.scan_cnt + 5'h01;
        end

        // laser decision, malfunction has the last word
        if (malfunction) begin // [R8]
            s_next.laser = 1'b0;
            ev[lest_pkg::IRQ_FAULT] = 1'b1;
        end else if (is_const_on(s_reg.mode)) begin // [R6]
            s_next.laser = 1'b1;
        end else if (s_reg.mode == lest_pkg::LEST_MODE_POLLING) begin
            s_next.laser = (s_reg.scan_cnt == POLL_LAST); // [R7]
        end else begin
            s_next.laser = pulse && !s_next.tripped; // [R1] [R2] [R4]
        end

        // daily statistics, volatile
        if (s_reg.sec_cyc == SEC_CYC - 32'h00000001) begin // [R10]
            s_next.sec_cyc   = 32'h00000000;
            s_next.hours_sec = s_reg.hours_sec + 32'h00000001;
        end else begin
            s_next.sec_cyc = s_reg.sec_cyc + 32'h00000001;
        end
        if (pulse_rise) begin
            s_next.intervals = s_reg.intervals + 32'h00000001;
            s_next.iv_len    = 32'h00000000;
        end else if (pulse) begin
            s_next.iv_len = s_reg.iv_len + 32'h00000001;
        end
        if (!pulse && s_reg.pulse_d) begin
            if (s_reg.iv_len > s_reg.max_iv) s_next.max_iv = s_reg.iv_len;
            if (s_reg.iv_len < s_reg.min_iv) s_next.min_iv = s_reg.iv_len;
        end
        if (good_read) begin
            s_next.good     = s_reg.good + 32'h00000001;
            s_next.qual_sum = s_reg.qual_sum + {24'h000000, ident_quality};
        end

        // write channel
        if (s_axi_awvalid && !s_reg.aw_got) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_got) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = lest_pkg::RESP_OKAY;
            case ({s_reg.awaddr[11:2], 2'b00})
                lest_pkg::ADDR_CTRL: begin
                    wv = merge({29'h0, s_reg.mode}, s_reg.wdata, s_reg.wstrb);
                    s_next.mode = wv[lest_pkg::CTRL_MODE_LSB +: lest_pkg::CTRL_MODE_W];
                end
                lest_pkg::ADDR_TIMEOUT: begin
                    wv = merge({21'h0, s_reg.tmo_min}, s_reg.wdata, s_reg.wstrb);
                    // 0 disables; otherwise clamp into 1 min..25 h
                    if (wv[10:0] == 11'h000) s_next.tmo_min = 11'h000; // [R5]
                    else if (wv[10:0] > TMO_HI) s_next.tmo_min = TMO_HI;
                    else if (wv[10:0] < TMO_LO) s_next.tmo_min = TMO_LO;
                    else s_next.tmo_min = wv[10:0];
                end
                lest_pkg::ADDR_IRQ_EN: s_next.irq_en = s_reg.wdata[IRQ_W_L-1:0];
                lest_pkg::ADDR_IRQ_CLR: s_next.irq_stat = s_reg.irq_stat & ~s_reg.wdata[IRQ_W_L-1:0];
                lest_pkg::ADDR_STORE: store_wr = 1'b1; // [R9]
                default: s_next.bresp = lest_pkg::RESP_SLVERR;
            endcase
        end
        if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
        // set wins over clear
        s_next.irq_stat = s_next.irq_stat | ev;

        // read channel
        stat_word = 32'h00000000;
        stat_word[lest_pkg::STAT_LASER]   = s_reg.laser;
        stat_word[lest_pkg::STAT_TIMEOUT] = s_reg.tripped;
        stat_word[lest_pkg::STAT_FAULT]   = malfunction;
        if (s_axi_arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = lest_pkg::RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                lest_pkg::ADDR_CTRL:      s_next.rdata = {29'h0, s_reg.mode};
                lest_pkg::ADDR_TIMEOUT:   s_next.rdata = {21'h0, s_reg.tmo_min};
                lest_pkg::ADDR_STATUS:    s_next.rdata = stat_word;
                lest_pkg::ADDR_IRQ_STAT:  s_next.rdata = {30'h0, s_reg.irq_stat};
                lest_pkg::ADDR_IRQ_EN:    s_next.rdata = {30'h0, s_reg.irq_en};
                lest_pkg::ADDR_IRQ_CLR:   s_next.rdata = 32'h00000000;
                lest_pkg::ADDR_STORE:     s_next.rdata = store_rd;
                lest_pkg::ADDR_HOURS:     s_next.rdata = s_reg.hours_sec;
                lest_pkg::ADDR_INTERVALS: s_next.rdata = s_reg.intervals;
                lest_pkg::ADDR_GOOD:      s_next.rdata = s_reg.good;
                lest_pkg::ADDR_MAXIV:     s_next.rdata = s_reg.max_iv;
                lest_pkg::ADDR_MINIV:     s_next.rdata = s_reg.min_iv;
                lest_pkg::ADDR_QUALITY:   s_next.rdata = s_reg.qual_sum;
                default: begin
                    s_next.rdata = 32'h00000000;
                    s_next.rresp = lest_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
    end

    // restart clears all volatile counters and stats except min_iv, which is set to all ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin // [R10]
            s_reg          <= '0;
            s_reg.boot     <= 1'b1;
            s_reg.tmo_min  <= TMO_DEF;
            s_reg.min_iv   <= lest_pkg::MINIV_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign laser_enable  = s_reg.laser && !malfunction; // [R8]
    assign timeout_msg   = s_reg.msg;
    assign irq           = |(s_reg.irq_stat & s_reg.irq_en);
    assign s_axi_awready = !s_reg.aw_got;
    assign s_axi_wready  = !s_reg.w_got;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rdata   = s_reg.rdata;
    assign s_axi_rresp   = s_reg.rresp;
endmodule
`default_nettype wire

// >>> tb/lest_laser_timer_props.sv
`timescale 1ns/10ps
`default_nettype none
module lest_timer_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        sensor_pulse,
    input wire logic        serial_pulse,
    input wire logic        malfunction,
    input wire logic        laser_enable,
    input wire logic        timeout_msg,
    input wire logic        irq,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // trip seen, then the source keeps the pulse up
    sequence s_tripped_held;
        timeout_msg ##1 (sensor_pulse || serial_pulse) [*3];
    endsequence
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_MALF_OFF: assert property (malfunction |-> !laser_enable)
        else $error("laser on during malfunction");
    AST_TRIP_OFF: assert property (timeout_msg |=> !laser_enable)
        else $error("laser on after trip");
    AST_MSG_SINGLE: assert property (timeout_msg |=> !timeout_msg)
        else $error("notification longer than one cycle");
    AST_MSG_HELD: assert property (timeout_msg |-> $past(sensor_pulse || serial_pulse, 2))
        else $error("trip without held pulse");
    AST_STAY_OFF: assert property (s_tripped_held |-> !laser_enable)
        else $error("laser back on within tripped pulse");
    AST_RESET_QUIET: assert property ($rose(aresetn) |-> !laser_enable && !irq)
        else $error("outputs active at reset release");
    AST_B_SOON: assert property (s_both_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
endmodule
`default_nettype wire

// >>> tb/lest_trigger_model.sv
`timescale 1ns/10ps
`default_nettype none
module lest_trigger_model (
    input  wire logic       aclk,
    input  wire logic       start,
    input  wire logic       use_serial,
    input  wire logic [7:0] hold_len,
    output logic            sensor_pulse,
    output logic            serial_pulse,
    output logic            active
);
    logic [7:0] left_reg = 8'h00;
    always @(posedge aclk) begin
        if (start) begin
            left_reg <= hold_len;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
    // source ends each pulse by itself, also after a trip
    assign active = (left_reg != 8'h00);
    assign sensor_pulse = active && !use_serial;
    assign serial_pulse = active && use_serial;
endmodule
`default_nettype wire

// >>> tb/lest_laser_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module lest_laser_timer_bench;
    localparam int unsigned MINC = 10;
    localparam logic [11:0] STAT_A [6] = '{lest_pkg::ADDR_HOURS, lest_pkg::ADDR_INTERVALS, lest_pkg::ADDR_GOOD,
        lest_pkg::ADDR_MAXIV, lest_pkg::ADDR_MINIV, lest_pkg::ADDR_QUALITY};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        scan_start = 1'b0, malfunction = 1'b0, good_read = 1'b0, trg_start = 1'b0, trg_ser = 1'b0;
    logic [7:0]  ident_quality = 8'h00, trg_len = 8'h00;
    logic        sensor_pulse, serial_pulse, trg_active, laser_enable, timeout_msg, irq;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    int          error_cnt = 0, n_compared = 0, cycles = 0;
    always #4 aclk = ~aclk;
    lest_laser_timer #(.MIN_CYCLES(MINC)) u_lest_laser_timer (.aclk, .aresetn, .sensor_pulse, .serial_pulse,
        .scan_start, .malfunction, .good_read, .ident_quality, .laser_enable, .timeout_msg, .irq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    lest_trigger_model u_lest_trigger_model (.aclk, .start(trg_start), .use_serial(trg_ser), .hold_len(trg_len),
        .sensor_pulse, .serial_pulse, .active(trg_active));
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard well above the thousand or so cycles needed
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_ok, w_ok, b_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = aw_ok | (s_axi_awvalid & (s_axi_awready === 1'b1));
            w_ok = w_ok | (s_axi_wvalid & (s_axi_wready === 1'b1));
            b_ok = (s_axi_bvalid === 1'b1);
            last_resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
        logic ar_ok, r_ok;
        ar_ok = 1'b0;
        r_ok = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_ok) begin
            @(negedge aclk);
            ar_ok = ar_ok | (s_axi_arvalid & (s_axi_arready === 1'b1));
            r_ok = (s_axi_rvalid === 1'b1);
            d = s_axi_rdata;
            last_resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        axi_rd(a, v);
        chk_word(v, exp);
    endtask
    task automatic fire(input logic [7:0] len, input logic ser);
        @(posedge aclk);
        trg_len <= len;
        trg_ser <= ser;
        trg_start <= 1'b1;
        @(posedge aclk);
        trg_start <= 1'b0;
    endtask
    task automatic wait_msg(input int limit, output int n);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (n < limit && timeout_msg !== 1'b1);
    endtask
    initial begin
        int n, tm, hits;
        logic [7:0] len;
        logic [31:0] v;
        n = $urandom(32'h25d4);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // store is unreset: program it, then restart
        axi_wr(lest_pkg::ADDR_STORE, 32'h0000_0100, 4'hF);
        good_read <= 1'b1;
        ident_quality <= 8'($urandom);
        @(posedge aclk);
        good_read <= 1'b0;
        rd_chk(lest_pkg::ADDR_GOOD, 32'h1);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(lest_pkg::ADDR_CTRL, 32'h0);
        rd_chk(lest_pkg::ADDR_TIMEOUT, 32'h1);
        foreach (STAT_A[i]) rd_chk(STAT_A[i], (STAT_A[i] == lest_pkg::ADDR_MINIV) ? lest_pkg::MINIV_RESET : 32'h0);
        $display("test restart done");
        for (int k = 0; k < 2; k++) begin
            tm = 1 + $urandom_range(2);
            len = 8'(2 + $urandom_range(5));
            axi_wr(lest_pkg::ADDR_CTRL, k, 4'h1);
            axi_wr(lest_pkg::ADDR_TIMEOUT, tm, 4'hF);
            axi_wr(lest_pkg::ADDR_IRQ_EN, 32'h1, 4'hF);
            fire(len, k[0]);
            idle(2);
            chk_bit(laser_enable, 1'b1);
            idle(len + 1);
            chk_bit(laser_enable, 1'b0);
            fire(8'hFF, k[0]);
            wait_msg(400, n);
            chk_bit(n + 1 >= tm * MINC && n <= tm * MINC + 3, 1'b1);
            idle(2);
            chk_bit(laser_enable, 1'b0);
            chk_bit(irq, 1'b1);
            rd_chk(lest_pkg::ADDR_IRQ_STAT, 32'h1);
            axi_wr(lest_pkg::ADDR_IRQ_EN, 32'h0, 4'hF);
            idle(1);
            chk_bit(irq, 1'b0);
            axi_wr(lest_pkg::ADDR_IRQ_CLR, 32'h1, 4'hF);
            rd_chk(lest_pkg::ADDR_IRQ_STAT, 32'h0);
            while (trg_active) @(negedge aclk);
            fire(8'h06, k[0]);
            idle(2);
            chk_bit(laser_enable, 1'b1);
            idle(6);
            $display("test trigger source %0d done", k);
        end
        axi_wr(lest_pkg::ADDR_CTRL, 32'h0, 4'hF);
        axi_wr(lest_pkg::ADDR_TIMEOUT, 32'h0, 4'hF);
        fire(8'hC8, 1'b0);
        wait_msg(220, n);
        chk_word(n, 220);
        axi_wr(lest_pkg::ADDR_TIMEOUT, 32'h000005DC, 4'hF);
        rd_chk(lest_pkg::ADDR_TIMEOUT, 32'h000005DC);
        $display("test timeout range done");
        for (int m = 3; m < 8; m++) begin
            axi_wr(lest_pkg::ADDR_CTRL, m, 4'hF);
            idle(3);
            chk_bit(laser_enable, 1'b1);
        end
        @(posedge aclk);
        malfunction <= 1'b1;
        idle(1);
        chk_bit(laser_enable, 1'b0);
        axi_rd(lest_pkg::ADDR_IRQ_STAT, v);
        chk_bit(v[lest_pkg::IRQ_FAULT], 1'b1);
        rd_chk(lest_pkg::ADDR_STATUS, 32'h1 << lest_pkg::STAT_FAULT);
        malfunction <= 1'b0;
        $display("test constant modes done");
        axi_wr(lest_pkg::ADDR_CTRL, 32'h2, 4'hF);
        hits = 0;
        repeat (40) begin
            @(posedge aclk);
            scan_start <= 1'b1;
            good_read <= 1'($urandom_range(1));
            ident_quality <= 8'($urandom);
            @(posedge aclk);
            scan_start <= 1'b0;
            good_read <= 1'b0;
            idle(1);
            hits += (laser_enable === 1'b1);
        end
        chk_word(hits, 2);
        axi_rd(12'h0FC, v);
        chk_word({30'h0, last_resp}, {30'h0, lest_pkg::RESP_SLVERR});
        axi_wr(12'h0FC, 32'h0, 4'hF);
        chk_word({30'h0, last_resp}, {30'h0, lest_pkg::RESP_SLVERR});
        $display("test polling done");
        tally_and_finish();
    end
endmodule
bind lest_laser_timer lest_timer_props u_props (.aclk, .aresetn, .sensor_pulse, .serial_pulse, .malfunction,
    .laser_enable, .timeout_msg, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
